// file: rtl/eef_defines.svh
// Constants of the Ethernet event-flag block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef EEF_DEFINES_SVH
`define EEF_DEFINES_SVH

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define EEF_OFF_FLAGS 16'h1004
`define EEF_OFF_MASK 16'h1008
`define EEF_OFF_ECTL 16'h1024
`define EEF_OFF_RCTL 16'h1084
`define EEF_OFF_TCTL 16'h10c4
`define EEF_OFF_CNT_SQE 16'h126c
`define EEF_OFF_CNT_RXOG 16'h1298
`define EEF_OFF_CNT_RXOB 16'h12a0
`define EEF_OFF_CNT_TXOG 16'h1218
`define EEF_OFF_CNT_TXOB 16'h1220
`define EEF_OFF_CNT_LCOL 16'h125c
`define EEF_OFF_CNT_EXCOL 16'h1260
`define EEF_OFF_CNT_UNDR 16'h1264

// ********************************************************************
// Counter indices
// ********************************************************************
`define EEF_CNT_NUM 8
`define EEF_CI_SQE 0
`define EEF_CI_RXOG 1
`define EEF_CI_RXOB 2
`define EEF_CI_TXOG 3
`define EEF_CI_TXOB 4
`define EEF_CI_LCOL 5
`define EEF_CI_EXCOL 6
`define EEF_CI_UNDR 7

// ********************************************************************
// Flag bit positions and reset values
// ********************************************************************
`define EEF_B_HB 31
`define EEF_B_BABBLING_RECEIVE_FLAG 30
`define EEF_B_BABBLING_TRANSMIT_FLAG 29
`define EEF_B_GRA 28
`define EEF_B_TXF 27
`define EEF_B_TXB 26
`define EEF_B_RXF 25
`define EEF_B_RXB 24
`define EEF_B_MII 23
`define EEF_B_SYSTEM_BUS_ERROR_FLAG 22
`define EEF_B_LC 21
`define EEF_B_RL 20
`define EEF_B_UN 19
`define EEF_FLAG_MASK 32'hfff80000
`define EEF_FLAGS_RST 32'h00000000
`define EEF_MASK_RST 32'h00000000
`define EEF_ECTL_EN_BIT 1
`define EEF_ECTL_RST 32'h00000000
`define EEF_TCTL_GTS_BIT 0
`define EEF_TCTL_HBC_BIT 1
`define EEF_TCTL_PAUSE_BIT 2
`define EEF_TCTL_RST 32'h00000000
`define EEF_RCTL_FL_LSB 16
`define EEF_RCTL_FL_MSB 26
`define EEF_RCTL_RST 32'h05ee0000
`define EEF_CNT_RST 32'h00000000
`define EEF_CNT_ONE 32'h00000001

// ********************************************************************
// Sizes, timing and bus answers
// ********************************************************************
`define EEF_LEN_W 11
`define EEF_RETRY_W 5
`define EEF_RETRY_LAST 5'h0f
`define EEF_CLK_NS 10
`define EEF_HB_WINDOW_NS 400
`define EEF_HB_CYCLES ((`EEF_HB_WINDOW_NS + `EEF_CLK_NS - 1) / `EEF_CLK_NS)
`define EEF_HB_CNT_W 6
`define EEF_RESP_OKAY 2'b00
`define EEF_RESP_SLVERR 2'b10

`endif

// file: rtl/eef_pkg.sv
// Types shared by the event-flag block: bus carriers and event bundle.
// Assumes eef_defines.svh supplies the widths.
`include "eef_defines.svh"

package eef_pkg;

	typedef struct packed {
		logic awvalid;
		logic [15:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [15:0] araddr;
		logic rready;
	} eef_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eef_axi_rsp_t;

	typedef struct packed {
		logic tx_frame_start;
		logic tx_frame_end;
		logic [`EEF_LEN_W-1:0] tx_len;
		logic tx_crc_ok;
		logic rx_frame_end;
		logic [`EEF_LEN_W-1:0] rx_len;
		logic rx_crc_ok;
		logic tx_frame_desc_done;
		logic tx_desc_update;
		logic rx_desc_update;
		logic rx_desc_last;
		logic mii_done;
		logic dma_bus_error;
		logic late_collision;
		logic tx_attempt_collision;
		logic fifo_underrun;
		logic pause_frame_rx;
		logic pause_frame_end;
	} eef_events_t;

endpackage : eef_pkg

// file: rtl/eef_heartbeat.sv
// Heartbeat checker: watches for collision after each transmission.
// Assumes collision_sync is already synchronised to ref_clk.
`timescale 1ns/1ns
`include "eef_defines.svh"

module eef_heartbeat (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic check_enable,
	input wire logic tx_done,
	input wire logic collision_sync,
	output logic error_pulse
);
	import eef_pkg::*;

	typedef enum logic {EEF_HB_IDLE, EEF_HB_WATCH} eef_hb_state_t;
	localparam logic [`EEF_HB_CNT_W-1:0] HB_LAST = `EEF_HB_CNT_W'(`EEF_HB_CYCLES - 1);

	eef_hb_state_t state_reg, state_next;
	logic [`EEF_HB_CNT_W-1:0] cnt_reg, cnt_next;
	logic err_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		err_next = 1'b0;
		unique case (state_reg)
			EEF_HB_IDLE: begin
				if (tx_done && check_enable) begin
					state_next = EEF_HB_WATCH;
					cnt_next = '0;
				end
			end
			EEF_HB_WATCH: begin
				if (collision_sync) begin
					state_next = EEF_HB_IDLE;
				end else if (cnt_reg == HB_LAST) begin
					state_next = EEF_HB_IDLE;
					err_next = 1'b1; // [RL6]
				end else begin
					cnt_next = cnt_reg + `EEF_HB_CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= EEF_HB_IDLE;
			cnt_reg <= '0;
			error_pulse <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			error_pulse <= err_next;
		end
	end

	hb_no_col_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL6]
		error_pulse |-> !$past(collision_sync))
		else $error("heartbeat error despite collision");

endmodule : eef_heartbeat

// file: rtl/eef_graceful_stop.sv
// Graceful stop sequencer: pauses the transmitter between frames.
// Assumes tx_busy is high for the whole of each frame being sent.
`timescale 1ns/1ns
`include "eef_defines.svh"

module eef_graceful_stop (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic stop_req,
	input wire logic pause_req,
	input wire logic pause_frame_rx,
	input wire logic pause_frame_end,
	input wire logic tx_busy,
	output logic paused,
	output logic done_pulse
);
	import eef_pkg::*;

	typedef enum logic [1:0] {EEF_GS_RUN, EEF_GS_DRAIN, EEF_GS_PAUSED} eef_gs_state_t;

	eef_gs_state_t state_reg, state_next;
	logic pf_hold_reg, pf_hold_next;
	logic any_req;
	logic done_next;

	always_comb begin
		pf_hold_next = pf_hold_reg;
		if (pause_frame_rx) begin
			pf_hold_next = 1'b1;
		end else if (pause_frame_end) begin
			pf_hold_next = 1'b0;
		end
		any_req = stop_req || pause_req || pf_hold_reg;
		state_next = state_reg;
		done_next = 1'b0;
		unique case (state_reg)
			EEF_GS_RUN: begin
				if (any_req) begin
					state_next = EEF_GS_DRAIN;
				end
			end
			EEF_GS_DRAIN: begin
				if (!any_req) begin
					state_next = EEF_GS_RUN;
				end else if (!tx_busy) begin
					// Current frame finished; never cut a frame short
					state_next = EEF_GS_PAUSED; // [RL9]
					done_next = 1'b1; // [RL10]
				end
			end
			EEF_GS_PAUSED: begin
				if (!any_req) begin
					state_next = EEF_GS_RUN;
				end
			end
			default: begin
				state_next = EEF_GS_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= EEF_GS_RUN;
			pf_hold_reg <= 1'b0;
			paused <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			state_reg <= state_next;
			pf_hold_reg <= pf_hold_next;
			paused <= (state_next == EEF_GS_PAUSED);
			done_pulse <= done_next;
		end
	end

	gs_after_frame_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RL9]
		$rose(paused) |-> !$past(tx_busy) && done_pulse)
		else $error("pause entered while frame still busy");

endmodule : eef_graceful_stop

// file: rtl/eef_top.sv
// Ethernet event-flag register with mask, control bits and error counters.
// Assumes event inputs are one-cycle pulses on ref_clk; col_pin is async.
//
// Overview of operation
// RL1: Interrupt only when flag and mask set
// RL2: Writing one clears flag; zero keeps it
// RL3: Reset clears every event flag
// RL4: Error events also bump their statistics counter
// RL5: Software may mask counted errors
// RL6: Heartbeat error when no collision after transmit
// RL7: Receive oversize frame sets babbling receive
// RL8: Transmit oversize sets babbling transmit, no truncation
// RL9: Graceful stop pauses after current frame
// RL10: Graceful stop completion sets its flag
// RL11: Transmit frame done after last descriptor
// RL12: Any transmit descriptor update sets flag
// RL13: Receive frame done after last descriptor
// RL14: Non-last receive descriptor update sets flag
// RL15: Management transfer done sets flag
// RL16: Bus error sets flag, clears global enable
// RL17: Late collision sets flag, bad CRC, discard
// RL18: Sixteen collided attempts set flag, discard frame
// RL19: Underrun sets flag, bad CRC, discard
// RL20: Low nineteen bits read zero
// RL21: Interrupt holds while any unmasked flag remains
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "eef_defines.svh"

module eef_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input eef_pkg::eef_axi_req_t axi_req,
	output eef_pkg::eef_axi_rsp_t axi_rsp,
	input eef_pkg::eef_events_t ev,
	input wire logic col_pin,
	input wire logic tx_busy,
	output logic irq,
	output logic ethernet_global_enable,
	output logic tx_paused,
	output logic tx_force_bad_crc,
	output logic tx_discard_frame
);
	import eef_pkg::*;

	// ********************************************************************
	// Helpers
	// ********************************************************************
	function automatic logic [31:0] strb_bits(input logic [3:0] strb);
		strb_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : strb_bits

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = (old & ~strb_bits(strb)) | (nw & strb_bits(strb));
	endfunction : merge

	function automatic logic oversize(input logic [`EEF_LEN_W-1:0] len,
		input logic [`EEF_LEN_W-1:0] max_len);
		oversize = len > max_len;
	endfunction : oversize

	// ********************************************************************
	// Collision pin synchroniser
	// ********************************************************************
	logic col_meta_reg, col_sync_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			col_meta_reg <= 1'b0;
			col_sync_reg <= 1'b0;
		end else begin
			col_meta_reg <= col_pin;
			col_sync_reg <= col_meta_reg;
		end
	end

	// ********************************************************************
	// State declarations
	// ********************************************************************
	eef_axi_rsp_t rsp_reg, rsp_next;
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [15:0] aw_addr_reg, aw_addr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic [31:0] flags_reg, flags_next;
	logic [31:0] mask_reg, mask_next;
	logic [31:0] ectl_reg, ectl_next;
	logic [31:0] tctl_reg, tctl_next;
	logic [31:0] rctl_reg, rctl_next;
	logic [31:0] cnt_reg [`EEF_CNT_NUM];
	logic [31:0] cnt_next [`EEF_CNT_NUM];
	logic [`EEF_RETRY_W-1:0] retry_reg, retry_next;
	logic irq_next, bad_crc_next, discard_next;
	logic wr_go, rd_go, wr_err;
	logic [31:0] set_vec, clr_vec, rd_data;
	logic rd_ok;
	logic [`EEF_CNT_NUM-1:0] inc;
	logic [`EEF_LEN_W-1:0] max_len;
	logic rx_big, tx_big, retry_hit, hb_err, gs_done, gs_paused;

	// ********************************************************************
	// Sub-blocks
	// ********************************************************************
	eef_heartbeat u_hb (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.check_enable(tctl_reg[`EEF_TCTL_HBC_BIT]),
		.tx_done(ev.tx_frame_end),
		.collision_sync(col_sync_reg),
		.error_pulse(hb_err)
	);

	eef_graceful_stop u_gs (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.stop_req(tctl_reg[`EEF_TCTL_GTS_BIT]),
		.pause_req(tctl_reg[`EEF_TCTL_PAUSE_BIT]),
		.pause_frame_rx(ev.pause_frame_rx),
		.pause_frame_end(ev.pause_frame_end),
		.tx_busy(tx_busy),
		.paused(gs_paused),
		.done_pulse(gs_done)
	);

	// ********************************************************************
	// AXI4-Lite slave
	// ********************************************************************
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		aw_addr_next = aw_addr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		rsp_next = rsp_reg;
		// Address and data are latched independently, in either order
		if (axi_req.awvalid && rsp_reg.awready) begin
			aw_held_next = 1'b1;
			aw_addr_next = axi_req.awaddr;
		end
		if (axi_req.wvalid && rsp_reg.wready) begin
			w_held_next = 1'b1;
			wdata_next = axi_req.wdata;
			wstrb_next = axi_req.wstrb;
		end
		wr_go = aw_held_reg && w_held_reg && !rsp_reg.bvalid;
		if (rsp_reg.bvalid && axi_req.bready) begin
			rsp_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			rsp_next.bvalid = 1'b1;
			rsp_next.bresp = wr_err ? `EEF_RESP_SLVERR : `EEF_RESP_OKAY;
		end
		rsp_next.awready = !aw_held_next;
		rsp_next.wready = !w_held_next;
		rd_go = axi_req.arvalid && rsp_reg.arready;
		if (rsp_reg.rvalid && axi_req.rready) begin
			rsp_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			rsp_next.rvalid = 1'b1;
			rsp_next.rdata = rd_ok ? rd_data : 32'h00000000;
			rsp_next.rresp = rd_ok ? `EEF_RESP_OKAY : `EEF_RESP_SLVERR;
		end
		// One read outstanding at a time keeps rdata stable
		rsp_next.arready = !rsp_next.rvalid;
	end

	// Read decode
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		case (axi_req.araddr)
			`EEF_OFF_FLAGS: rd_data = flags_reg & `EEF_FLAG_MASK; // [RL20]
			`EEF_OFF_MASK: rd_data = mask_reg;
			`EEF_OFF_ECTL: rd_data = ectl_reg;
			`EEF_OFF_RCTL: rd_data = rctl_reg;
			`EEF_OFF_TCTL: rd_data = tctl_reg;
			`EEF_OFF_CNT_SQE: rd_data = cnt_reg[`EEF_CI_SQE];
			`EEF_OFF_CNT_RXOG: rd_data = cnt_reg[`EEF_CI_RXOG];
			`EEF_OFF_CNT_RXOB: rd_data = cnt_reg[`EEF_CI_RXOB];
			`EEF_OFF_CNT_TXOG: rd_data = cnt_reg[`EEF_CI_TXOG];
			`EEF_OFF_CNT_TXOB: rd_data = cnt_reg[`EEF_CI_TXOB];
			`EEF_OFF_CNT_LCOL: rd_data = cnt_reg[`EEF_CI_LCOL];
			`EEF_OFF_CNT_EXCOL: rd_data = cnt_reg[`EEF_CI_EXCOL];
			`EEF_OFF_CNT_UNDR: rd_data = cnt_reg[`EEF_CI_UNDR];
			default: rd_ok = 1'b0;
		endcase
	end

	// ********************************************************************
	// Event detection
	// ********************************************************************
	always_comb begin
		max_len = rctl_reg[`EEF_RCTL_FL_MSB:`EEF_RCTL_FL_LSB];
		rx_big = ev.rx_frame_end && oversize(ev.rx_len, max_len); // [RL7]
		// Oversize transmit is only reported; the frame is sent whole
		tx_big = ev.tx_frame_end && oversize(ev.tx_len, max_len); // [RL8]
		retry_next = retry_reg;
		retry_hit = 1'b0;
		if (ev.tx_frame_start) begin
			retry_next = '0;
		end else if (ev.tx_attempt_collision) begin
			if (retry_reg == `EEF_RETRY_LAST) begin
				retry_hit = 1'b1; // [RL18]
				retry_next = '0;
			end else begin
				retry_next = retry_reg + `EEF_RETRY_W'(1);
			end
		end
		set_vec = 32'h00000000;
		set_vec[`EEF_B_HB] = hb_err; // [RL6]
		set_vec[`EEF_B_BABBLING_RECEIVE_FLAG] = rx_big; // [RL7]
		set_vec[`EEF_B_BABBLING_TRANSMIT_FLAG] = tx_big; // [RL8]
		set_vec[`EEF_B_GRA] = gs_done; // [RL10]
		set_vec[`EEF_B_TXF] = ev.tx_frame_desc_done; // [RL11]
		set_vec[`EEF_B_TXB] = ev.tx_desc_update; // [RL12]
		set_vec[`EEF_B_RXF] = ev.rx_desc_update && ev.rx_desc_last; // [RL13]
		set_vec[`EEF_B_RXB] = ev.rx_desc_update && !ev.rx_desc_last; // [RL14]
		set_vec[`EEF_B_MII] = ev.mii_done; // [RL15]
		set_vec[`EEF_B_SYSTEM_BUS_ERROR_FLAG] = ev.dma_bus_error; // [RL16]
		set_vec[`EEF_B_LC] = ev.late_collision; // [RL17]
		set_vec[`EEF_B_RL] = retry_hit; // [RL18]
		set_vec[`EEF_B_UN] = ev.fifo_underrun; // [RL19]
		// Counters run whatever the mask holds
		inc[`EEF_CI_SQE] = hb_err; // [RL4]
		inc[`EEF_CI_RXOG] = rx_big && ev.rx_crc_ok; // [RL4]
		inc[`EEF_CI_RXOB] = rx_big && !ev.rx_crc_ok; // [RL4]
		inc[`EEF_CI_TXOG] = tx_big && ev.tx_crc_ok; // [RL4]
		inc[`EEF_CI_TXOB] = tx_big && !ev.tx_crc_ok; // [RL4]
		inc[`EEF_CI_LCOL] = ev.late_collision; // [RL4]
		inc[`EEF_CI_EXCOL] = retry_hit; // [RL4]
		inc[`EEF_CI_UNDR] = ev.fifo_underrun; // [RL4]
		bad_crc_next = ev.late_collision || ev.fifo_underrun; // [RL17] [RL19]
		discard_next = ev.late_collision || ev.fifo_underrun || retry_hit; // [RL17] [RL18] [RL19]
	end

	// ********************************************************************
	// Register file next state
	// ********************************************************************
	always_comb begin
		flags_next = flags_reg;
		mask_next = mask_reg;
		ectl_next = ectl_reg;
		tctl_next = tctl_reg;
		rctl_next = rctl_reg;
		wr_err = 1'b0;
		clr_vec = 32'h00000000;
		if (wr_go) begin
			case (aw_addr_reg)
				`EEF_OFF_FLAGS: clr_vec = wdata_reg & strb_bits(wstrb_reg); // [RL2]
				`EEF_OFF_MASK: mask_next = merge(mask_reg, wdata_reg, wstrb_reg);
				`EEF_OFF_ECTL: ectl_next = merge(ectl_reg, wdata_reg, wstrb_reg);
				`EEF_OFF_RCTL: rctl_next = merge(rctl_reg, wdata_reg, wstrb_reg);
				`EEF_OFF_TCTL: tctl_next = merge(tctl_reg, wdata_reg, wstrb_reg);
				`EEF_OFF_CNT_SQE, `EEF_OFF_CNT_RXOG, `EEF_OFF_CNT_RXOB,
				`EEF_OFF_CNT_TXOG, `EEF_OFF_CNT_TXOB, `EEF_OFF_CNT_LCOL,
				`EEF_OFF_CNT_EXCOL, `EEF_OFF_CNT_UNDR: wr_err = 1'b0;
				default: wr_err = 1'b1;
			endcase
		end
		mask_next = mask_next & `EEF_FLAG_MASK;
		// A new event beats a same-cycle clear
		flags_next = ((flags_reg & ~clr_vec) | set_vec) & `EEF_FLAG_MASK; // [RL2] [RL20]
		if (ev.dma_bus_error) begin
			ectl_next[`EEF_ECTL_EN_BIT] = 1'b0; // [RL16]
		end
		irq_next = |(flags_reg & mask_reg); // [RL1] [RL21]
		for (int i = 0; i < `EEF_CNT_NUM; i++) begin
			cnt_next[i] = inc[i] ? cnt_reg[i] + `EEF_CNT_ONE : cnt_reg[i];
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_reg <= '0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			flags_reg <= `EEF_FLAGS_RST; // [RL3]
			mask_reg <= `EEF_MASK_RST;
			ectl_reg <= `EEF_ECTL_RST;
			tctl_reg <= `EEF_TCTL_RST;
			rctl_reg <= `EEF_RCTL_RST;
			for (int i = 0; i < `EEF_CNT_NUM; i++) begin
				cnt_reg[i] <= `EEF_CNT_RST;
			end
			retry_reg <= '0;
			irq <= 1'b0;
			ethernet_global_enable <= 1'b0;
			tx_paused <= 1'b0;
			tx_force_bad_crc <= 1'b0;
			tx_discard_frame <= 1'b0;
		end else begin
			rsp_reg <= rsp_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			aw_addr_reg <= aw_addr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			flags_reg <= flags_next;
			mask_reg <= mask_next;
			ectl_reg <= ectl_next;
			tctl_reg <= tctl_next;
			rctl_reg <= rctl_next;
			for (int i = 0; i < `EEF_CNT_NUM; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
			retry_reg <= retry_next;
			irq <= irq_next;
			ethernet_global_enable <= ectl_next[`EEF_ECTL_EN_BIT];
			tx_paused <= gs_paused;
			tx_force_bad_crc <= bad_crc_next;
			tx_discard_frame <= discard_next;
		end
	end

	assign axi_rsp = rsp_reg;

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence rd_take_s;
		axi_req.arvalid && rsp_reg.arready;
	endsequence

	sequence rd_answer_s;
		rsp_reg.rvalid && !rsp_reg.arready;
	endsequence

	read_answer_a: assert property (rd_take_s |=> rd_answer_s)
		else $error("read not answered next cycle");

	irq_raise_a: assert property (|(flags_reg & mask_reg) |=> irq) // [RL1]
		else $error("unmasked flag without interrupt");

	irq_drop_a: assert property (irq && $past(!(|(flags_reg & mask_reg))) |-> 1'b0) // [RL21]
		else $error("interrupt held with no unmasked flag");

	set_wins_a: assert property (set_vec != 32'h00000000 |=> // [RL2]
		(flags_reg & $past(set_vec)) == $past(set_vec))
		else $error("event lost against clear");

	w1c_clear_a: assert property (wr_go && aw_addr_reg == `EEF_OFF_FLAGS // [RL2]
		&& set_vec == '0 |=> (flags_reg & $past(clr_vec)) == 32'h00000000)
		else $error("write one did not clear flag");

	// A same-cycle event may still set an uncleared bit
	zero_keeps_a: assert property (wr_go && aw_addr_reg == `EEF_OFF_FLAGS // [RL2]
		|=> (flags_reg & ~$past(clr_vec)) == (($past(flags_reg) | $past(set_vec))
		& ~$past(clr_vec)))
		else $error("write zero changed flag");

	low_bits_a: assert property (flags_reg[18:0] == 19'h00000) // [RL20]
		else $error("reserved flag bits set");

	bus_err_a: assert property (ev.dma_bus_error |=> // [RL16]
		!ethernet_global_enable && flags_reg[`EEF_B_SYSTEM_BUS_ERROR_FLAG])
		else $error("bus error did not disable controller");

	rx_count_a: assert property (rx_big && ev.rx_crc_ok |=> // [RL4]
		cnt_reg[`EEF_CI_RXOG] == $past(cnt_reg[`EEF_CI_RXOG]) + `EEF_CNT_ONE)
		else $error("oversize receive not counted");

	underrun_a: assert property (ev.fifo_underrun |=> // [RL19]
		tx_force_bad_crc && tx_discard_frame && flags_reg[`EEF_B_UN])
		else $error("underrun not handled");

	retry_a: assert property (retry_hit |=> // [RL18]
		flags_reg[`EEF_B_RL] && tx_discard_frame && retry_reg == '0)
		else $error("retry limit not handled");

endmodule : eef_top

// file: verification/eef_phy_model.sv
// Far-side model: transmitter busy level and heartbeat collision answer.
// Assumes frame start and end pulses come from the bench on ref_clk.
`timescale 1ns/1ns

module eef_phy_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic tx_start,
	input wire logic tx_end,
	input wire logic sqe_on,
	output logic col_pin,
	output logic tx_busy
);
	logic [3:0] cnt;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 4'h0;
			tx_busy <= 1'b0;
		end else begin
			if (tx_start)
				tx_busy <= 1'b1;
			else if (tx_end)
				tx_busy <= 1'b0;
			if (tx_end && sqe_on)
				cnt <= 4'h8;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
	// Late answer, well inside the window; line idles low
	assign col_pin = (cnt != 4'h0) && (cnt < 4'h4);
endmodule : eef_phy_model

// file: verification/test_ethernet_event_flag_register.sv
// Bench for the event-flag block: AXI4-Lite tasks and event pulses.
// Assumes the design files and eef_phy_model are compiled first.
`timescale 1ns/1ns
`include "eef_defines.svh"

module test_ethernet_event_flag_register;
	import eef_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic col_pin, tx_busy, irq, en, paused, bad, disc;
	logic sqe_on = 1'b0;
	eef_axi_req_t q = '0;
	eef_axi_rsp_t r;
	eef_events_t ev = '0;
	eef_events_t e;
	logic [31:0] d;
	logic [1:0] rs;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int bad_n = 0;
	int disc_n = 0;
	int bits [8] = '{23, 26, 27, 24, 25, 21, 19, 22};

	always #5 ref_clk = ~ref_clk;

	eef_top i_eef_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .axi_req(q), .axi_rsp(r),
		.ev(ev), .col_pin(col_pin), .tx_busy(tx_busy), .irq(irq),
		.ethernet_global_enable(en), .tx_paused(paused), .tx_force_bad_crc(bad),
		.tx_discard_frame(disc));
	eef_phy_model i_eef_phy_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.tx_start(ev.tx_frame_start), .tx_end(ev.tx_frame_end), .sqe_on(sqe_on),
		.col_pin(col_pin), .tx_busy(tx_busy));

	// ****
	// Tasks
	// ****
	task close_out;
		$display("mismatches %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		q.awvalid <= 1'b1;
		q.awaddr <= a;
		q.wvalid <= 1'b1;
		q.wdata <= v;
		q.wstrb <= 4'hf;
		q.bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (r.awready)
				q.awvalid <= 1'b0;
			if (r.wready)
				q.wvalid <= 1'b0;
			if (r.bvalid)
				break;
		end
		q.bready <= 1'b0;
	endtask : wr

	task rd(input logic [15:0] a);
		@(posedge ref_clk);
		q.arvalid <= 1'b1;
		q.araddr <= a;
		q.rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (r.arready)
				q.arvalid <= 1'b0;
			if (r.rvalid)
				break;
		end
		d = r.rdata;
		rs = r.rresp;
		q.rready <= 1'b0;
	endtask : rd

	task rdchk(input string n, input logic [15:0] a, input logic [31:0] x);
		rd(a);
		chk(n, x, d);
	endtask : rdchk

	task pulse(input eef_events_t x);
		@(posedge ref_clk);
		ev <= x;
		@(posedge ref_clk);
		ev <= '0;
		repeat (2) @(posedge ref_clk);
	endtask : pulse

	always @(posedge ref_clk) begin
		cyc++;
		if (bad)
			bad_n++;
		if (disc)
			disc_n++;
		if (cyc == 20000) begin
			err_count++;
			close_out;
		end
	end

	// ****
	// Tests
	// ****
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rdchk("flags", `EEF_OFF_FLAGS, 32'h0);
		rdchk("mask", `EEF_OFF_MASK, 32'h0);
		wr(`EEF_OFF_MASK, 32'hffffffff);
		rdchk("mask", `EEF_OFF_MASK, 32'hfff80000);
		wr(`EEF_OFF_MASK, 32'h0);
		wr(`EEF_OFF_ECTL, 32'h2);
		chk("enable", 32'h1, {31'h0, en});
		for (int i = 0; i < 8; i++) begin
			e = '0;
			case (i)
				0: e.mii_done = 1'b1;
				1: e.tx_desc_update = 1'b1;
				2: e.tx_frame_desc_done = 1'b1;
				3: e.rx_desc_update = 1'b1;
				4: {e.rx_desc_update, e.rx_desc_last} = 2'b11;
				5: e.late_collision = 1'b1;
				6: e.fifo_underrun = 1'b1;
				default: e.dma_bus_error = 1'b1;
			endcase
			pulse(e);
			rdchk("set", `EEF_OFF_FLAGS, 32'h1 << bits[i]);
			wr(`EEF_OFF_FLAGS, ~(32'h1 << bits[i]));
			rdchk("kept", `EEF_OFF_FLAGS, 32'h1 << bits[i]);
			wr(`EEF_OFF_FLAGS, 32'h1 << bits[i]);
			rdchk("clear", `EEF_OFF_FLAGS, 32'h0);
		end
		chk("enable", 32'h0, {31'h0, en});
		rdchk("lcol", `EEF_OFF_CNT_LCOL, 32'h1);
		rdchk("undr", `EEF_OFF_CNT_UNDR, 32'h1);
		e = '0;
		e.mii_done = 1'b1;
		pulse(e);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`EEF_OFF_MASK, 32'h00800000);
		repeat (2) @(posedge ref_clk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`EEF_OFF_FLAGS, 32'h00800000);
		repeat (2) @(posedge ref_clk);
		chk("irq", 32'h0, {31'h0, irq});
		e = '0;
		e.rx_frame_end = 1'b1;
		e.rx_crc_ok = 1'b1;
		e.rx_len = 11'd1518;
		pulse(e);
		rdchk("rx", `EEF_OFF_FLAGS, 32'h0);
		e.rx_len = 11'd1519;
		pulse(e);
		rdchk("rx", `EEF_OFF_FLAGS, 32'h40000000);
		rdchk("rxog", `EEF_OFF_CNT_RXOG, 32'h1);
		wr(`EEF_OFF_FLAGS, 32'hffffffff);
		e = '0;
		e.tx_frame_start = 1'b1;
		pulse(e);
		wr(`EEF_OFF_TCTL, 32'h1);
		rdchk("gs", `EEF_OFF_FLAGS, 32'h0);
		chk("paused", 32'h0, {31'h0, paused});
		e = '0;
		e.tx_frame_end = 1'b1;
		e.tx_len = 11'd1519;
		pulse(e);
		rdchk("gs", `EEF_OFF_FLAGS, 32'h30000000);
		chk("paused", 32'h1, {31'h0, paused});
		rdchk("txob", `EEF_OFF_CNT_TXOB, 32'h1);
		wr(`EEF_OFF_FLAGS, 32'hffffffff);
		wr(`EEF_OFF_TCTL, 32'h2);
		e.tx_len = 11'd64;
		sqe_on <= 1'b1;
		pulse(e);
		repeat (50) @(posedge ref_clk);
		rdchk("hb", `EEF_OFF_FLAGS, 32'h0);
		sqe_on <= 1'b0;
		pulse(e);
		repeat (50) @(posedge ref_clk);
		rdchk("hb", `EEF_OFF_FLAGS, 32'h80000000);
		rdchk("sqe", `EEF_OFF_CNT_SQE, 32'h1);
		e = '0;
		e.tx_frame_start = 1'b1;
		pulse(e);
		e = '0;
		e.tx_attempt_collision = 1'b1;
		repeat (15) pulse(e);
		rdchk("rl", `EEF_OFF_FLAGS, 32'h80000000);
		pulse(e);
		rdchk("rl", `EEF_OFF_FLAGS, 32'h80100000);
		rdchk("excol", `EEF_OFF_CNT_EXCOL, 32'h1);
		chk("disc", 32'd3, disc_n);
		chk("badcrc", 32'd2, bad_n);
		rd(16'h1ffc);
		chk("resp", 32'h2, {30'h0, rs});
		close_out;
	end
endmodule : test_ethernet_event_flag_register
